// *** mpt_map.svh ***
`ifndef MPT_MAP_SVH
`define MPT_MAP_SVH

// Register byte offsets, one 32-bit word each
`define MPT_OFF_MODE 8'h00
`define MPT_OFF_CTRL 8'h04
`define MPT_OFF_STATUS 8'h08
`define MPT_OFF_COUNTER 8'h0c
`define MPT_OFF_BUF_U 8'h10
`define MPT_OFF_BUF_V 8'h14
`define MPT_OFF_BUF_W 8'h18
`define MPT_OFF_FREE_U 8'h1c
`define MPT_OFF_FREE_V 8'h20
`define MPT_OFF_FREE_W 8'h24
`define MPT_OFF_CMP_FIRST 8'h28
`define MPT_OFF_CMP_LAST 8'h48
`define MPT_OFF_DTC_FIRST 8'h4c
`define MPT_OFF_DTC_LAST 8'h60
`define MPT_OFF_DT_DATA 8'h64
`define MPT_OFF_PER_BUF 8'h68
`define MPT_OFF_PER_DATA 8'h6c
`define MPT_OFF_PIN_EN 8'h70

// Control bit positions
`define MPT_CTRL_START 6
`define MPT_CTRL_PROTECT 5
`define MPT_CTRL_TROUGH_IEN 1
`define MPT_CTRL_CREST_IEN 0
// Status bit positions
`define MPT_STAT_DIR 7
`define MPT_STAT_TROUGH 1
`define MPT_STAT_CREST 0
// Pin enable: bit 0 clear input, bit 1 toggle, bits 7..2 pwm
`define MPT_PIN_CLEAR 0
`define MPT_PIN_TOGGLE 1
`define MPT_PIN_PWM_LSB 2

// Reset values, half-word strobe and counter step
`define MPT_RST_BYTE 8'h00
`define MPT_RST_WORD 16'h0000
`define MPT_RST_DTC 16'h0000
`define MPT_STRB_HALF 2'h3
`define MPT_ONE16 16'h0001

`endif

// *** mpt_pkg.sv ***
package mpt_pkg;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [3:0] pstrb;
    logic [31:0] pwdata;
  } mpt_apb_req_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } mpt_apb_rsp_s;

  // Mode register fields (bits 3..0)
  typedef struct packed {
    logic level_neg;
    logic level_pos;
    logic transfer_mode_high;
    logic transfer_mode_low;
  } mpt_mode_s;

  typedef struct packed {
    logic start;
    logic register_protect;
    logic trough_irq_enable;
    logic crest_irq_enable;
  } mpt_ctrl_s;

  typedef enum logic [2:0] {
    ST_HALT = 3'b001,
    ST_UP = 3'b010,
    ST_DOWN = 3'b100
  } mpt_count_e;

  typedef logic [15:0] mpt_word_t;

endpackage

// *** mpt_timer.sv ***
// Contract
// - Trough interrupt request follows trough flag while trough enable (ctrl bit 1) set.
// - Crest interrupt request follows crest flag while crest enable (ctrl bit 0) set.
// - Status bit 7 read-only count direction, 1 up, 0 down, resets to 1.
// - Trough flag (status bit 1) sets when counter equals twice dead time.
// - Crest flag (status bit 0) sets when counter equals period data.
// - Flags clear only by writing 0 after reading 1; writing 1 no effect.
// - Reserved control bits 4..2 and status bits 6..2 read 0.
// - Counter is 16 bits, 16-bit accesses only.
// - Buffered phase address transfers to compares at mode-selected timing.
// - Direct phase address stores buffer and passes value to compares.
// - Nine 16-bit compare registers, three per phase, 16-bit access only.
// - Dead-time counters 16-bit, read-only, writes ignored.
// - 16-bit dead-time data sets non-overlap between positive and negative outputs.
// - Period buffer transfers to period data at mode-selected timing, 16-bit only.
// - Counter compared with period data; equality turns counting up to down.
// - Protect bit set disables software access to protected registers.
// - Pin enable bits 7..2 pwm pins, bit 1 toggle pin, reset 0.
// - Pin enable bit 0 hands shared pin to counter clear input.
// - Mode field 00 halt, 01 crest, 10 trough, 11 both.
// - Counter runs from twice dead time up to period data and back.
// - Direct address write reaches compares at once.
`timescale 1ns/100ps
`include "mpt_map.svh"

module mpt_timer (
  input wire logic clk,
  input wire logic srst,
  input wire mpt_pkg::mpt_apb_req_s apb_req,
  output mpt_pkg::mpt_apb_rsp_s apb_rsp,
  input wire logic counter_clear_n,
  output logic [5:0] pwm_out,
  output logic [5:0] pwm_pin_sel,
  output logic period_toggle_output,
  output logic toggle_pin_sel,
  output logic clear_pin_sel,
  output logic trough_irq,
  output logic crest_irq
);

  // Sum cut to 16 bits; software keeps ranges so it never wraps
  function automatic mpt_pkg::mpt_word_t add16(input mpt_pkg::mpt_word_t a, input mpt_pkg::mpt_word_t b);
    add16 = 16'(a + b);
  endfunction

  mpt_pkg::mpt_mode_s mode, next_mode;
  mpt_pkg::mpt_ctrl_s ctrl, next_ctrl;
  mpt_pkg::mpt_count_e state, next_state;
  mpt_pkg::mpt_apb_rsp_s next_rsp;
  logic trough_match_flag, next_trough_flag, crest_match_flag, next_crest_flag;
  logic [1:0] armed, next_armed;
  mpt_pkg::mpt_word_t up_down_counter, next_counter;
  mpt_pkg::mpt_word_t phase_buffer [3];
  mpt_pkg::mpt_word_t next_buffer [3];
  mpt_pkg::mpt_word_t phase_compare [9];
  mpt_pkg::mpt_word_t next_compare [9];
  mpt_pkg::mpt_word_t dead_time_counter [6];
  mpt_pkg::mpt_word_t next_dtc [6];
  mpt_pkg::mpt_word_t dead_time_data, next_dtd, period_buffer, next_pbuf, period_data, next_pdat;
  logic [7:0] pin_function_enable, next_pin_en;
  logic [5:0] raw_q, next_raw_q, next_pwm;
  logic next_toggle, next_trough_irq, next_crest_irq;

  // Bus decode, shared by the answer cycle and the completing edge
  logic acc, wr_go, rd_go, hit, half, prot_rd, prot_wr, err;
  logic [31:0] rd_val;
  mpt_pkg::mpt_word_t two_td, wd;
  logic running, at_crest, at_trough, dir_up;
  logic [5:0] raw;
  int idx, fidx;

  assign acc = apb_req.psel & apb_req.penable;
  assign wr_go = acc & apb_rsp.pready & apb_req.pwrite;
  assign rd_go = acc & apb_rsp.pready & ~apb_req.pwrite;
  assign wd = apb_req.pwdata[15:0];
  assign fidx = int'((apb_req.paddr - `MPT_OFF_FREE_U) >> 2); // Phase of a direct address
  assign two_td = add16(dead_time_data, dead_time_data);
  assign dir_up = (state != mpt_pkg::ST_DOWN);
  assign running = ctrl.start & (mode.transfer_mode_high | mode.transfer_mode_low)
                   & ~(pin_function_enable[`MPT_PIN_CLEAR] & ~counter_clear_n);
  assign at_crest = running & (state == mpt_pkg::ST_UP) & (up_down_counter == period_data);
  assign at_trough = running & (state == mpt_pkg::ST_DOWN) & (up_down_counter == two_td);

  // Read mux and access checks
  always_comb begin
    idx = 0;
    rd_val = 32'h0000_0000;
    hit = 1'b1;
    half = 1'b1;
    prot_rd = ctrl.register_protect;
    prot_wr = ctrl.register_protect;
    if (apb_req.paddr >= `MPT_OFF_CMP_FIRST && apb_req.paddr <= `MPT_OFF_CMP_LAST) begin
      idx = int'((apb_req.paddr - `MPT_OFF_CMP_FIRST) >> 2);
      rd_val[15:0] = phase_compare[idx];
    end else if (apb_req.paddr >= `MPT_OFF_DTC_FIRST && apb_req.paddr <= `MPT_OFF_DTC_LAST) begin
      idx = int'((apb_req.paddr - `MPT_OFF_DTC_FIRST) >> 2);
      rd_val[15:0] = dead_time_counter[idx];
    end else begin
      unique case (apb_req.paddr)
        `MPT_OFF_MODE: begin
          rd_val[3:0] = mode;
          half = 1'b0;
        end
        `MPT_OFF_CTRL: begin
          rd_val[`MPT_CTRL_START] = ctrl.start;
          rd_val[`MPT_CTRL_PROTECT] = ctrl.register_protect;
          rd_val[`MPT_CTRL_TROUGH_IEN] = ctrl.trough_irq_enable;
          rd_val[`MPT_CTRL_CREST_IEN] = ctrl.crest_irq_enable;
          half = 1'b0;
        end
        `MPT_OFF_STATUS: begin
          rd_val[`MPT_STAT_DIR] = dir_up;
          rd_val[`MPT_STAT_TROUGH] = trough_match_flag;
          rd_val[`MPT_STAT_CREST] = crest_match_flag;
          half = 1'b0;
          prot_rd = 1'b0;
          prot_wr = 1'b0;
        end
        `MPT_OFF_COUNTER: rd_val[15:0] = up_down_counter;
        `MPT_OFF_BUF_U, `MPT_OFF_FREE_U: begin
          rd_val[15:0] = phase_buffer[0];
          prot_wr = 1'b0;
        end
        `MPT_OFF_BUF_V, `MPT_OFF_FREE_V: begin
          rd_val[15:0] = phase_buffer[1];
          prot_wr = 1'b0;
        end
        `MPT_OFF_BUF_W, `MPT_OFF_FREE_W: begin
          rd_val[15:0] = phase_buffer[2];
          prot_wr = 1'b0;
        end
        `MPT_OFF_DT_DATA: rd_val[15:0] = dead_time_data;
        `MPT_OFF_PER_BUF: begin
          rd_val[15:0] = period_buffer;
          prot_wr = 1'b0;
        end
        `MPT_OFF_PER_DATA: rd_val[15:0] = period_data;
        `MPT_OFF_PIN_EN: begin
          rd_val[7:0] = pin_function_enable;
          half = 1'b0;
        end
        default: hit = 1'b0;
      endcase
    end
    // Narrow writes to 16-bit registers and blocked accesses are refused
    if (apb_req.pwrite) begin
      err = ~hit | prot_wr
            | (half ? (apb_req.pstrb[1:0] != `MPT_STRB_HALF) : ~apb_req.pstrb[0]);
    end else begin
      err = ~hit | prot_rd;
    end
  end

  // APB answer: one wait state, so read data and error leave a flop
  always_comb begin
    next_rsp.pready = acc & ~apb_rsp.pready;
    next_rsp.pslverr = acc & ~apb_rsp.pready & err;
    next_rsp.prdata = (acc & ~apb_rsp.pready & ~apb_req.pwrite & ~err) ? rd_val : 32'h0000_0000;
  end

  // Raw compare outputs; positive phases on even bits
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      raw[2 * p] = dir_up ? (up_down_counter < phase_compare[3 * p])
                          : (up_down_counter < phase_compare[3 * p + 2]);
      raw[2 * p + 1] = ~raw[2 * p] & (up_down_counter >= phase_compare[3 * p + 1]) | ~raw[2 * p];
    end
  end

  // Timer, register and pin next-state logic
  always_comb begin
    next_mode = mode;
    next_ctrl = ctrl;
    next_state = state;
    next_counter = up_down_counter;
    next_buffer = phase_buffer;
    next_compare = phase_compare;
    next_dtc = dead_time_counter;
    next_dtd = dead_time_data;
    next_pbuf = period_buffer;
    next_pdat = period_data;
    next_pin_en = pin_function_enable;
    next_toggle = period_toggle_output;
    next_armed = armed;
    next_trough_flag = trough_match_flag;
    next_crest_flag = crest_match_flag;
    next_raw_q = running ? raw : 6'h00;
    next_pwm = 6'h00;

    // Counter runs between twice dead time and period data
    if (!running) begin
      next_state = mpt_pkg::ST_HALT;
      next_counter = two_td;
    end else begin
      unique case (state)
        mpt_pkg::ST_HALT: begin
          next_state = mpt_pkg::ST_UP;
          next_counter = add16(up_down_counter, `MPT_ONE16);
        end
        mpt_pkg::ST_UP: begin
          if (at_crest) begin
            next_state = mpt_pkg::ST_DOWN;
            next_counter = 16'(up_down_counter - `MPT_ONE16);
            next_toggle = ~period_toggle_output;
          end else begin
            next_counter = add16(up_down_counter, `MPT_ONE16);
          end
        end
        mpt_pkg::ST_DOWN: begin
          if (at_trough) begin
            next_state = mpt_pkg::ST_UP;
            next_counter = add16(up_down_counter, `MPT_ONE16);
          end else begin
            next_counter = 16'(up_down_counter - `MPT_ONE16);
          end
        end
      endcase
    end

    // Buffered transfer at the selected peak
    if ((at_crest & mode.transfer_mode_low) | (at_trough & mode.transfer_mode_high)) begin
      for (int p = 0; p < 3; p++) begin
        next_compare[3 * p] = add16(phase_buffer[p], two_td);
        next_compare[3 * p + 1] = add16(phase_buffer[p], dead_time_data);
        next_compare[3 * p + 2] = phase_buffer[p];
      end
      next_pdat = add16(period_buffer, two_td);
    end

    // Dead-time counters start on an output turning on, clear to 0 on reaching the set value
    for (int k = 0; k < 6; k++) begin
      if (!running) begin
        next_dtc[k] = `MPT_RST_DTC;
      end else if (dead_time_counter[k] != `MPT_RST_DTC) begin
        next_dtc[k] = (dead_time_counter[k] == dead_time_data) ? `MPT_RST_DTC
                      : add16(dead_time_counter[k], `MPT_ONE16);
      end else if (raw[k] & ~raw_q[k] & (dead_time_data != `MPT_RST_WORD)) begin
        next_dtc[k] = `MPT_ONE16;
      end
      // Output active only after the non-overlap gap expires
      next_pwm[k] = (running & raw[k] & raw_q[k] & (dead_time_counter[k] == `MPT_RST_DTC))
                    ? ((k % 2 == 0) ? mode.level_pos : mode.level_neg)
                    : ~((k % 2 == 0) ? mode.level_pos : mode.level_neg);
    end

    // Reading a flag as 1 arms its clear
    if (rd_go && apb_req.paddr == `MPT_OFF_STATUS) begin
      next_armed = next_armed | {trough_match_flag, crest_match_flag};
    end

    // Completed writes
    if (wr_go && !err) begin
      if (apb_req.paddr >= `MPT_OFF_CMP_FIRST && apb_req.paddr <= `MPT_OFF_CMP_LAST) begin
        next_compare[idx] = wd;
      end else begin
        unique case (apb_req.paddr)
          `MPT_OFF_MODE: next_mode = apb_req.pwdata[3:0];
          `MPT_OFF_CTRL: begin
            next_ctrl.start = apb_req.pwdata[`MPT_CTRL_START];
            next_ctrl.register_protect = apb_req.pwdata[`MPT_CTRL_PROTECT];
            next_ctrl.trough_irq_enable = apb_req.pwdata[`MPT_CTRL_TROUGH_IEN];
            next_ctrl.crest_irq_enable = apb_req.pwdata[`MPT_CTRL_CREST_IEN];
          end
          `MPT_OFF_STATUS: begin
            // Writing 1 leaves a flag alone; an unarmed 0 does nothing
            if (!apb_req.pwdata[`MPT_STAT_TROUGH] && armed[1]) begin
              next_trough_flag = 1'b0;
              next_armed[1] = 1'b0;
            end
            if (!apb_req.pwdata[`MPT_STAT_CREST] && armed[0]) begin
              next_crest_flag = 1'b0;
              next_armed[0] = 1'b0;
            end
          end
          `MPT_OFF_COUNTER: next_counter = wd;
          `MPT_OFF_BUF_U: next_buffer[0] = wd;
          `MPT_OFF_BUF_V: next_buffer[1] = wd;
          `MPT_OFF_BUF_W: next_buffer[2] = wd;
          `MPT_OFF_FREE_U, `MPT_OFF_FREE_V, `MPT_OFF_FREE_W: begin
            next_buffer[fidx] = wd;
            next_compare[3 * fidx] = add16(wd, two_td);
            next_compare[3 * fidx + 1] = add16(wd, dead_time_data);
            next_compare[3 * fidx + 2] = wd;
          end
          `MPT_OFF_DT_DATA: next_dtd = wd;
          `MPT_OFF_PER_BUF: next_pbuf = wd;
          `MPT_OFF_PER_DATA: next_pdat = wd;
          `MPT_OFF_PIN_EN: next_pin_en = apb_req.pwdata[7:0];
          default: ; // Dead-time counters ignore writes
        endcase
      end
    end

    // A match in the clearing cycle wins
    if (at_trough) begin
      next_trough_flag = 1'b1;
    end
    if (at_crest) begin
      next_crest_flag = 1'b1;
    end
    next_trough_irq = next_trough_flag & next_ctrl.trough_irq_enable;
    next_crest_irq = next_crest_flag & next_ctrl.crest_irq_enable;
  end

  // State registers; protect stays until reset
  always_ff @(posedge clk) begin
    if (srst) begin
      apb_rsp <= '0;
      mode <= '0;
      ctrl <= '0;
      state <= mpt_pkg::ST_HALT;
      up_down_counter <= `MPT_RST_WORD;
      phase_buffer <= '{default: `MPT_RST_WORD};
      phase_compare <= '{default: `MPT_RST_WORD};
      dead_time_counter <= '{default: `MPT_RST_DTC};
      dead_time_data <= `MPT_RST_WORD;
      period_buffer <= `MPT_RST_WORD;
      period_data <= `MPT_RST_WORD;
      pin_function_enable <= `MPT_RST_BYTE;
      armed <= 2'h0;
      trough_match_flag <= 1'b0;
      crest_match_flag <= 1'b0;
      raw_q <= 6'h00;
      period_toggle_output <= 1'b0;
      pwm_out <= 6'h00;
      pwm_pin_sel <= 6'h00;
      toggle_pin_sel <= 1'b0;
      clear_pin_sel <= 1'b0;
      trough_irq <= 1'b0;
      crest_irq <= 1'b0;
    end else begin
      apb_rsp <= next_rsp;
      mode <= next_mode;
      ctrl <= next_ctrl;
      state <= next_state;
      up_down_counter <= next_counter;
      phase_buffer <= next_buffer;
      phase_compare <= next_compare;
      dead_time_counter <= next_dtc;
      dead_time_data <= next_dtd;
      period_buffer <= next_pbuf;
      period_data <= next_pdat;
      pin_function_enable <= next_pin_en;
      armed <= next_armed;
      trough_match_flag <= next_trough_flag;
      crest_match_flag <= next_crest_flag;
      raw_q <= next_raw_q;
      period_toggle_output <= next_toggle;
      pwm_out <= next_pwm;
      pwm_pin_sel <= next_pin_en[7:`MPT_PIN_PWM_LSB];
      toggle_pin_sel <= next_pin_en[`MPT_PIN_TOGGLE];
      clear_pin_sel <= next_pin_en[`MPT_PIN_CLEAR];
      trough_irq <= next_trough_irq;
      crest_irq <= next_crest_irq;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_trough_irq_follow: assert property (trough_irq == (trough_match_flag && ctrl.trough_irq_enable))
    else $error("trough request mismatch");
  a_crest_irq_gate: assert property (!ctrl.crest_irq_enable |-> !crest_irq)
    else $error("crest request while disabled");
  a_trough_flag_set: assert property (at_trough |=> trough_match_flag ##0 dir_up)
    else $error("trough flag not set");
  a_crest_turn_down: assert property (at_crest |=> crest_match_flag && state == mpt_pkg::ST_DOWN)
    else $error("crest did not set flag and turn");
  a_flag_write_one: assert property ((wr_go && apb_req.paddr == `MPT_OFF_STATUS && apb_req.pwdata[0]
    && crest_match_flag) |=> crest_match_flag)
    else $error("writing 1 cleared flag");
  a_status_rsvd_zero: assert property ((rd_go && apb_req.paddr == `MPT_OFF_STATUS)
    |-> apb_rsp.prdata[6:2] == 5'h00)
    else $error("reserved status bits set");
  a_narrow_refused: assert property ((acc && !apb_rsp.pready && apb_req.pwrite
    && apb_req.paddr == `MPT_OFF_COUNTER && apb_req.pstrb[1:0] != 2'h3) |=> apb_rsp.pslverr)
    else $error("narrow counter write accepted");
  a_free_direct: assert property ((wr_go && !err && apb_req.paddr == `MPT_OFF_FREE_U)
    |=> phase_compare[2] == $past(wd) && phase_buffer[0] == $past(wd))
    else $error("direct write not passed on");
  a_protect_hold: assert property ((ctrl.register_protect && wr_go && apb_req.paddr == `MPT_OFF_CTRL)
    |=> $stable(ctrl))
    else $error("protected control changed");

  c_crest_seen: cover property (at_crest ##[1:300] at_trough);
  c_flag_cleared: cover property (crest_match_flag ##1 !crest_match_flag);
  c_protect_err: cover property (ctrl.register_protect && apb_rsp.pslverr);

endmodule // mpt_timer

// *** mpt_gate_model.sv ***
`timescale 1ns/100ps
// Far-side gate driver stage and counter clear source
module mpt_gate_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic [5:0] pwm_out,
  input wire logic [5:0] pwm_pin_sel,
  input wire logic period_toggle_output,
  input wire logic toggle_pin_sel,
  input wire logic trip,
  output logic counter_clear_n,
  output logic [5:0] gate_on,
  output logic [15:0] toggle_edges
);
  logic last_toggle;
  // Clear line has a pull-up, pulled low only while tripped
  assign counter_clear_n = ~trip;
  // Unrouted pins never reach a gate
  assign gate_on = pwm_out & pwm_pin_sel;
  // Count carrier toggles seen on the routed pin
  always_ff @(posedge clk) begin
    if (srst) begin
      last_toggle <= 1'b0;
      toggle_edges <= 16'h0000;
    end else begin
      last_toggle <= period_toggle_output;
      if (toggle_pin_sel && (period_toggle_output != last_toggle)) begin
        toggle_edges <= toggle_edges + 16'h0001;
      end
    end
  end
endmodule // mpt_gate_model

// *** three_phase_pwm_timer_registers_tb_top.sv ***
`timescale 1ns/100ps
`include "mpt_map.svh"
module three_phase_pwm_timer_registers_tb_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic trip = 1'b0;
  mpt_pkg::mpt_apb_req_s req = '0;
  mpt_pkg::mpt_apb_rsp_s rsp;
  logic clear_n, tog, tog_sel, clr_sel, trough_irq, crest_irq;
  logic [5:0] pwm, pin_sel;
  logic [15:0] edges;
  logic [31:0] rdata;
  logic err;
  int miscompares = 0;
  int cmp_count = 0;
  // 125 MHz clock
  always #4 clk = ~clk;
  mpt_timer dut_u (.clk(clk), .srst(srst), .apb_req(req), .apb_rsp(rsp), .counter_clear_n(clear_n),
    .pwm_out(pwm), .pwm_pin_sel(pin_sel), .period_toggle_output(tog), .toggle_pin_sel(tog_sel),
    .clear_pin_sel(clr_sel), .trough_irq(trough_irq), .crest_irq(crest_irq));
  mpt_gate_model drv_u (.clk(clk), .srst(srst), .pwm_out(pwm), .pwm_pin_sel(pin_sel),
    .period_toggle_output(tog), .toggle_pin_sel(tog_sel), .trip(trip), .counter_clear_n(clear_n),
    .gate_on(), .toggle_edges(edges));
  task automatic summarize();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // Setup then access, held until pready is seen at an edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= d;
    req.pstrb <= s;
    @(posedge clk);
    req.penable <= 1'b1;
    // No assumed latency; only the watchdog ends a hung access
    do begin
      @(posedge clk);
    end while (rsp.pready !== 1'b1);
    rdata = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0, 4'h0);
    chk(32'(err), 32'h0, "read refused");
    chk(rdata, exp, "read data");
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 4'hf);
    chk(32'(err), 32'h0, "write refused");
  endtask
  task automatic bad(input logic w, input logic [7:0] a, input logic [3:0] s);
    xfer(w, a, 32'h0, s);
    chk(32'(err), 32'h1, "refusal missing");
  endtask
  // Bounded wait on one of the request levels
  task automatic wait_irq(input bit trough);
    int n;
    n = 0;
    while ((trough ? trough_irq : crest_irq) !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk(32'(n < 200), 32'h1, "request never rose");
  endtask
  // Hang guard, far beyond the few hundred cycles the sequence needs
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    summarize();
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    rd(`MPT_OFF_STATUS, 32'h80);
    rd(`MPT_OFF_CTRL, 32'h0);
    rd(`MPT_OFF_PIN_EN, 32'h0);
    bad(1'b0, 8'h7c, 4'h0);
    wr(`MPT_OFF_PIN_EN, 32'hfe);
    rd(`MPT_OFF_PIN_EN, 32'hfe);
    chk({24'h0, pin_sel, tog_sel, clr_sel}, 32'hfe, "pin routing");
    wr(`MPT_OFF_DT_DATA, 32'h2);
    rd(`MPT_OFF_DT_DATA, 32'h2);
    chk(32'(pwm), 32'h3f, "idle pwm level");
    wr(`MPT_OFF_CTRL, 32'h43);
    rd(`MPT_OFF_CTRL, 32'h43);
    rd(`MPT_OFF_COUNTER, 32'h4);
    bad(1'b1, `MPT_OFF_COUNTER, 4'h1);
    bad(1'b1, `MPT_OFF_CMP_FIRST, 4'h1);
    wr(`MPT_OFF_DTC_FIRST, 32'h1234);
    rd(`MPT_OFF_DTC_FIRST, 32'h0);
    // Direct address: compares follow at once, offset by two, one and zero dead times
    wr(`MPT_OFF_FREE_U, 32'h10);
    rd(8'h28, 32'h14);
    rd(8'h2c, 32'h12);
    rd(8'h30, 32'h10);
    rd(`MPT_OFF_BUF_U, 32'h10);
    wr(`MPT_OFF_PER_BUF, 32'd40);
    wr(`MPT_OFF_PER_DATA, 32'd44);
    wr(`MPT_OFF_BUF_U, 32'h20);
    rd(8'h30, 32'h10);
    wr(`MPT_OFF_MODE, 32'h1);
    // Crest: flag, turn down, transfer in crest mode
    wait_irq(1'b0);
    rd(`MPT_OFF_STATUS, 32'h01);
    rd(8'h30, 32'h20);
    rd(8'h28, 32'h24);
    rd(`MPT_OFF_PER_DATA, 32'd44);
    wr(`MPT_OFF_STATUS, 32'h0);
    repeat (2) @(posedge clk);
    chk(32'(crest_irq), 32'h0, "crest request held");
    rd(`MPT_OFF_STATUS, 32'h00);
    // Trough: clearing needs a prior read of the flag as one
    wait_irq(1'b1);
    wr(`MPT_OFF_STATUS, 32'h0);
    rd(`MPT_OFF_STATUS, 32'h82);
    wr(`MPT_OFF_CTRL, 32'h41);
    repeat (2) @(posedge clk);
    chk(32'(trough_irq), 32'h0, "masked request");
    wr(`MPT_OFF_STATUS, 32'h2);
    rd(`MPT_OFF_STATUS, 32'h82);
    wr(`MPT_OFF_STATUS, 32'h0);
    rd(`MPT_OFF_STATUS, 32'h80);
    chk(32'(edges != 16'h0), 32'h1, "no carrier toggle");
    // Counter clear input holds the counter at twice the dead time
    wr(`MPT_OFF_PIN_EN, 32'h01);
    trip <= 1'b1;
    repeat (3) @(posedge clk);
    rd(`MPT_OFF_COUNTER, 32'h4);
    chk(32'(clr_sel), 32'h1, "clear pin routing");
    trip <= 1'b0;
    for (int m = 3; m >= 0; m--) begin
      wr(`MPT_OFF_MODE, 32'(m));
      rd(`MPT_OFF_MODE, 32'(m));
    end
    // Protect locks everything but buffer writes and status until reset
    wr(`MPT_OFF_CTRL, 32'h20);
    bad(1'b0, `MPT_OFF_CTRL, 4'h0);
    bad(1'b1, `MPT_OFF_PIN_EN, 4'hf);
    bad(1'b0, `MPT_OFF_BUF_V, 4'h0);
    wr(`MPT_OFF_BUF_V, 32'h5);
    xfer(1'b0, `MPT_OFF_STATUS, 32'h0, 4'h0);
    chk(32'(err), 32'h0, "status read locked");
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd(`MPT_OFF_CTRL, 32'h0);
    summarize();
  end
endmodule // three_phase_pwm_timer_registers_tb_top
